// ===== common/fgr_pkg.sv
// constants and types for the fine granularity refresh controller
package fgr_pkg;
  typedef logic [7:0] cyc_t;

  localparam int CLK_PERIOD_NS = 50;
  localparam int TREFI_BASE_NS = 7800;
  localparam int TRFC1_NS = 350;
  localparam int TRFC2_NS = 260;
  localparam int TRFC4_NS = 160;
  localparam int TXS_NS = 360;

  // the interval is a longest time and rounds down, the others round up
  localparam cyc_t TREFI_BASE_CYC = cyc_t'(TREFI_BASE_NS / CLK_PERIOD_NS);
  localparam cyc_t TRFC1_CYC = cyc_t'((TRFC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam cyc_t TRFC2_CYC = cyc_t'((TRFC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam cyc_t TRFC4_CYC = cyc_t'((TRFC4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam cyc_t TXS_CYC = cyc_t'((TXS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // refresh mode field: bit 2 marks on-the-fly, bits 1:0 the rate
  localparam logic [2:0] MODE_FIX1X = 3'h0;
  localparam logic [2:0] MODE_FIX2X = 3'h1;
  localparam logic [2:0] MODE_FIX4X = 3'h2;
  localparam logic [2:0] MODE_OTF12 = 3'h5;
  localparam logic [2:0] MODE_OTF14 = 3'h6;
  localparam int MODE_OTF_BIT = 2;

  localparam logic [1:0] FLV_1X = 2'h0;
  localparam logic [1:0] FLV_2X = 2'h1;
  localparam logic [1:0] FLV_4X = 2'h2;
  localparam logic [1:0] BAND_MAX = 2'h2;

  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_REFCNT = 4'hC;

  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_TCR_BIT = 3;
  localparam int CFG_TEMP_LSB = 4;
  localparam int CFG_FINE_BIT = 6;
  localparam int CFG_HOLD_BIT = 7;
  localparam int CMD_APPLY_BIT = 0;
  localparam int CMD_SRE_BIT = 1;
  localparam int CMD_SRX_BIT = 2;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [3:0] OWED_MAX = 4'hF;
  localparam logic [2:0] EXTRA_1X = 3'h1;
  localparam logic [2:0] EXTRA_2X = 3'h2;
  localparam logic [2:0] EXTRA_4X = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DRAIN = 3'h1,
    ST_TCROFF = 3'h2,
    ST_SETMODE = 3'h3,
    ST_INSR = 3'h4
  } ctrl_state_e;
endpackage : fgr_pkg

// ===== verilog/refresh_timer.sv
// loadable down counter used for refresh interval and busy windows
`timescale 1ns/1ns
`default_nettype none
module refresh_timer #(
  parameter int W = 8
) (
  input wire logic mclk, // clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic load, // restart the count
  input wire logic [W-1:0] loadValue, // value loaded on restart
  output logic [W-1:0] count, // cycles still to run
  output logic expired, // last cycle of a count
  output logic busy // count still running
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  assign busy = count_q != '0;
  assign expired = count_q == W'(1);
  assign count = count_q;
  assign count_d = load ? loadValue : (busy ? count_q - W'(1) : count_q);

  always_ff @(posedge mclk) begin
    if (!resetn) count_q <= '0;
    else count_q <= count_d;
  end
endmodule : refresh_timer
`default_nettype wire

// ===== verilog/ref_group_counter.sv
// modulo two or four count of fine refresh commands
`timescale 1ns/1ns
`default_nettype none
module ref_group_counter (
  input wire logic mclk, // clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic inc, // one fine refresh issued
  input wire logic clear, // start a new group
  input wire logic modFour, // count modulo four, else two
  output logic [1:0] count, // refreshes in the open group
  output logic zero // group is complete
);
  logic [1:0] count_q;
  logic [1:0] count_d;

  assign count_d = clear ? 2'h0 :
                   !inc ? count_q :
                   modFour ? count_q + 2'h1 : {1'b0, ~count_q[0]};
  assign count = count_q;
  assign zero = count_q == 2'h0;

  always_ff @(posedge mclk) begin
    if (!resetn) count_q <= 2'h0;
    else count_q <= count_d;
  end
endmodule : ref_group_counter
`default_nettype wire

// ===== verilog/fgr_refresh_ctrl.sv
// controller that issues refresh, rate change and self refresh commands
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module fgr_refresh_ctrl (
  input wire logic mclk, // clock, 20 MHz
  input wire logic resetn, // synchronous reset, active low
  input wire logic [3:0] regAddr, // register byte address
  input wire logic [31:0] regWdata, // register write data
  input wire logic regWrite, // write strobe
  input wire logic regRead, // read strobe
  output logic [31:0] regRdata, // read data, cycle after the strobe
  output logic refStrobe, // refresh command
  output logic [1:0] refFlavour, // 1x, 2x or 4x refresh
  output logic mrsStrobe, // refresh mode register write
  output logic [2:0] mrsMode, // refresh mode field value
  output logic mrsTcr, // temperature controlled refresh enable
  output logic sreStrobe, // self refresh entry
  output logic srxStrobe // self refresh exit
);
  fgr_pkg::ctrl_state_e state_q;
  fgr_pkg::ctrl_state_e state_d;
  logic [7:0] cfg_q;
  logic applyReq_q;
  logic sreReq_q;
  logic srxReq_q;
  logic [2:0] activeMode_q;
  logic activeTcr_q;
  logic [3:0] owed_q;
  logic [2:0] extra_q;
  logic owedAtEntry_q;
  logic [15:0] refCount_q;
  logic [31:0] rdata_q;
  logic refStrobe_q;
  logic [1:0] refFlavour_q;
  logic mrsStrobe_q;
  logic [2:0] mrsMode_q;
  logic mrsTcr_q;
  logic sreStrobe_q;
  logic srxStrobe_q;

  logic rfcBusy;
  logic intExpired;
  logic [7:0] intCount;
  logic [1:0] fineCount;
  logic fineZero;

  // register decode
  wire wrCfg = regWrite && regAddr == fgr_pkg::ADDR_CFG;
  wire wrCmd = regWrite && regAddr == fgr_pkg::ADDR_CMD;
  wire [2:0] pendMode = cfg_q[fgr_pkg::CFG_MODE_LSB +: 3];
  wire pendTcr = cfg_q[fgr_pkg::CFG_TCR_BIT];
  wire [1:0] tempBand = cfg_q[fgr_pkg::CFG_TEMP_LSB +: 2];
  wire preferFine = cfg_q[fgr_pkg::CFG_FINE_BIT];
  wire holdRef = cfg_q[fgr_pkg::CFG_HOLD_BIT];

  // mode decode
  wire [1:0] activeRate = activeMode_q[1:0];
  wire activeOtf = activeMode_q[fgr_pkg::MODE_OTF_BIT];
  wire rateChange = pendMode[1:0] != activeRate;
  wire needDrain = rateChange && activeRate != fgr_pkg::FLV_1X && !fineZero;
  wire needTcrOff = activeTcr_q && pendMode != fgr_pkg::MODE_FIX1X;
  wire newTcr = pendTcr && pendMode == fgr_pkg::MODE_FIX1X;
  wire oneXAllowed = activeRate == fgr_pkg::FLV_1X || activeOtf;

  // sequencing
  wire servingExtra = extra_q != 3'h0;
  wire idleFree = state_q == fgr_pkg::ST_IDLE && !rfcBusy;
  wire changeOk = applyReq_q && !servingExtra;
  wire sreOk = sreReq_q && !servingExtra;
  wire startChange = idleFree && changeOk;
  wire startSre = idleFree && !changeOk && sreOk;
  wire drainDone = state_q == fgr_pkg::ST_DRAIN && fineZero && !rfcBusy;
  wire tcrOffGo = state_q == fgr_pkg::ST_TCROFF;
  wire modeSet = state_q == fgr_pkg::ST_SETMODE;
  wire srxGo = state_q == fgr_pkg::ST_INSR && srxReq_q;

  // refresh choice: a 1x refresh only closes a complete fine group
  wire pickOneX = activeRate == fgr_pkg::FLV_1X ||
                  (activeOtf && fineZero && state_q != fgr_pkg::ST_DRAIN &&
                   (servingExtra ? extra_q == fgr_pkg::EXTRA_1X : !preferFine));
  wire [1:0] nextFlavour = pickOneX ? fgr_pkg::FLV_1X : activeRate;
  wire refWanted = state_q == fgr_pkg::ST_DRAIN ? !fineZero :
                   (servingExtra || (owed_q != 4'h0 && !holdRef));
  wire idleRefOk = state_q == fgr_pkg::ST_IDLE && !changeOk && !sreOk;
  wire refGo = !rfcBusy && refWanted && (idleRefOk || state_q == fgr_pkg::ST_DRAIN);
  wire fineInc = refGo && nextFlavour != fgr_pkg::FLV_1X;
  wire fineClear = (refGo && nextFlavour == fgr_pkg::FLV_1X) || srxGo || modeSet;

  // busy window after each refresh or self refresh exit
  wire [7:0] rfcLen = nextFlavour == fgr_pkg::FLV_1X ? fgr_pkg::TRFC1_CYC :
                      nextFlavour == fgr_pkg::FLV_2X ? fgr_pkg::TRFC2_CYC :
                      fgr_pkg::TRFC4_CYC;
  wire [7:0] rfcLoadVal = srxGo ? fgr_pkg::TXS_CYC : rfcLen;
  wire rfcLoad = refGo || srxGo;

  // average interval follows the regular flavour and temperature band
  wire [1:0] bandEff = tempBand > fgr_pkg::BAND_MAX ? fgr_pkg::BAND_MAX : tempBand;
  // the mode being written sets the interval loaded at the same edge
  wire [2:0] intervalMode = modeSet ? pendMode : activeMode_q;
  wire [1:0] intervalFlv = (intervalMode[fgr_pkg::MODE_OTF_BIT] && !preferFine) ?
                           fgr_pkg::FLV_1X : intervalMode[1:0];
  wire [2:0] intervalShift = {1'b0, intervalFlv} + {1'b0, bandEff};
  wire [7:0] intervalLen = fgr_pkg::TREFI_BASE_CYC >> intervalShift;
  wire intBusy = intCount != 8'h00;
  // reload on the last cycle so one interval is exactly intervalLen cycles
  wire intLoad = !intBusy || intExpired || modeSet || srxGo;
  wire owedInc = intExpired && !modeSet && !srxGo && state_q != fgr_pkg::ST_INSR;

  // postponed debt and post-exit extras are tracked apart
  wire owedDec = refGo && !servingExtra && owed_q != 4'h0;
  wire owedStep = owedInc && owed_q != fgr_pkg::OWED_MAX;
  wire [3:0] owed_d = owed_q + {3'h0, owedStep} - {3'h0, owedDec};
  wire [2:0] extraLoad = oneXAllowed ? fgr_pkg::EXTRA_1X :
                         activeRate == fgr_pkg::FLV_2X ? fgr_pkg::EXTRA_2X :
                         fgr_pkg::EXTRA_4X;
  wire [2:0] extra_d = srxGo ? (owedAtEntry_q ? extraLoad : 3'h0) :
                       (refGo && servingExtra) ? extra_q - 3'h1 : extra_q;

  // software requests; set wins over the clear
  wire applySet = wrCmd && regWdata[fgr_pkg::CMD_APPLY_BIT];
  wire sreSet = wrCmd && regWdata[fgr_pkg::CMD_SRE_BIT] && state_q != fgr_pkg::ST_INSR;
  wire srxSet = wrCmd && regWdata[fgr_pkg::CMD_SRX_BIT] && state_q == fgr_pkg::ST_INSR;
  wire applyReq_d = applySet || (applyReq_q && !startChange);
  wire sreReq_d = sreSet || (sreReq_q && !startSre);
  wire srxReq_d = srxSet || (srxReq_q && !srxGo);

  wire [2:0] activeMode_d = modeSet ? pendMode : activeMode_q;
  wire activeTcr_d = modeSet ? newTcr : (tcrOffGo ? 1'b0 : activeTcr_q);
  wire [2:0] mrsMode_d = modeSet ? pendMode : (tcrOffGo ? activeMode_q : mrsMode_q);
  wire mrsTcr_d = modeSet ? newTcr : (tcrOffGo ? 1'b0 : mrsTcr_q);
  wire owedAtEntry_d = startSre ? !fineZero : owedAtEntry_q;
  wire changeBusy = applyReq_q || (state_q != fgr_pkg::ST_IDLE && state_q != fgr_pkg::ST_INSR);
  wire inSr = state_q == fgr_pkg::ST_INSR;

  // register read mux
  wire [31:0] statusWord = {9'h000, state_q, 1'b0, extra_q, owed_q, 2'h0, fineCount,
                            owedAtEntry_q, changeBusy, inSr, rfcBusy, activeTcr_q,
                            activeMode_q};
  wire [31:0] readMux = regAddr == fgr_pkg::ADDR_CFG ? {24'h000000, cfg_q} :
                        regAddr == fgr_pkg::ADDR_STATUS ? statusWord :
                        regAddr == fgr_pkg::ADDR_REFCNT ? {16'h0000, refCount_q} :
                        32'h00000000;
  wire [31:0] rdata_d = regRead ? readMux : 32'h00000000;

  refresh_timer #(.W(8)) intervalTimer (
    .mclk(mclk),
    .resetn(resetn),
    .load(intLoad),
    .loadValue(intervalLen),
    .count(intCount),
    .expired(intExpired),
    .busy()
  );

  refresh_timer #(.W(8)) rfcTimer (
    .mclk(mclk),
    .resetn(resetn),
    .load(rfcLoad),
    .loadValue(rfcLoadVal),
    .count(),
    .expired(),
    .busy(rfcBusy)
  );

  ref_group_counter groupCount (
    .mclk(mclk),
    .resetn(resetn),
    .inc(fineInc),
    .clear(fineClear),
    .modFour(activeRate == fgr_pkg::FLV_4X),
    .count(fineCount),
    .zero(fineZero)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      fgr_pkg::ST_IDLE: begin
        if (startChange) begin
          if (needDrain) state_d = fgr_pkg::ST_DRAIN;
          else if (needTcrOff) state_d = fgr_pkg::ST_TCROFF;
          else state_d = fgr_pkg::ST_SETMODE;
        end else if (startSre) begin
          state_d = fgr_pkg::ST_INSR;
        end
      end
      fgr_pkg::ST_DRAIN: begin
        if (drainDone) state_d = needTcrOff ? fgr_pkg::ST_TCROFF : fgr_pkg::ST_SETMODE;
      end
      fgr_pkg::ST_TCROFF: state_d = fgr_pkg::ST_SETMODE;
      fgr_pkg::ST_SETMODE: state_d = fgr_pkg::ST_IDLE;
      fgr_pkg::ST_INSR: begin
        if (srxReq_q) state_d = fgr_pkg::ST_IDLE;
      end
      default: state_d = fgr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= fgr_pkg::ST_IDLE;
      cfg_q <= fgr_pkg::CFG_RESET;
      applyReq_q <= 1'b0;
      sreReq_q <= 1'b0;
      srxReq_q <= 1'b0;
      activeMode_q <= fgr_pkg::MODE_FIX1X;
      activeTcr_q <= 1'b0;
      owed_q <= 4'h0;
      extra_q <= 3'h0;
      owedAtEntry_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cfg_q <= wrCfg ? regWdata[7:0] : cfg_q;
      applyReq_q <= applyReq_d;
      sreReq_q <= sreReq_d;
      srxReq_q <= srxReq_d;
      activeMode_q <= activeMode_d;
      activeTcr_q <= activeTcr_d;
      owed_q <= owed_d;
      extra_q <= extra_d;
      owedAtEntry_q <= owedAtEntry_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      refCount_q <= 16'h0000;
      rdata_q <= 32'h00000000;
      refStrobe_q <= 1'b0;
      refFlavour_q <= fgr_pkg::FLV_1X;
      mrsStrobe_q <= 1'b0;
      mrsMode_q <= fgr_pkg::MODE_FIX1X;
      mrsTcr_q <= 1'b0;
      sreStrobe_q <= 1'b0;
      srxStrobe_q <= 1'b0;
    end else begin
      refCount_q <= refGo ? refCount_q + 16'h0001 : refCount_q;
      rdata_q <= rdata_d;
      refStrobe_q <= refGo;
      refFlavour_q <= refGo ? nextFlavour : refFlavour_q;
      mrsStrobe_q <= tcrOffGo || modeSet;
      mrsMode_q <= mrsMode_d;
      mrsTcr_q <= mrsTcr_d;
      sreStrobe_q <= startSre;
      srxStrobe_q <= srxGo;
    end
  end

  assign regRdata = rdata_q;
  assign refStrobe = refStrobe_q;
  assign refFlavour = refFlavour_q;
  assign mrsStrobe = mrsStrobe_q;
  assign mrsMode = mrsMode_q;
  assign mrsTcr = mrsTcr_q;
  assign sreStrobe = sreStrobe_q;
  assign srxStrobe = srxStrobe_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_tcr_then_mode;
    modeSet ##1 (mrsStrobe_q && !activeTcr_q);
  endsequence

  sequence s_owed_exit;
    srxStrobe_q && extra_q != 3'h0;
  endsequence

  chk_spacing_one_x: assert property (
    refStrobe_q && refFlavour_q == fgr_pkg::FLV_1X |=> !refStrobe_q [*7])
    else $error("1x refresh followed too soon");
  chk_spacing_two_x: assert property (
    refStrobe_q && refFlavour_q == fgr_pkg::FLV_2X |=> !refStrobe_q [*6])
    else $error("2x refresh followed too soon");
  chk_spacing_four_x: assert property (
    refStrobe_q && refFlavour_q == fgr_pkg::FLV_4X |=> !refStrobe_q [*4])
    else $error("4x refresh followed too soon");
  chk_fixed_flavour: assert property (
    refStrobe_q && !activeOtf |-> refFlavour_q == activeRate)
    else $error("refresh flavour not allowed in fixed mode");
  chk_group_before_1x: assert property (
    refStrobe_q && refFlavour_q == fgr_pkg::FLV_1X && activeOtf |-> $past(fineZero))
    else $error("1x refresh inside an open fine group");
  chk_drain_before_mrs: assert property (
    modeSet && rateChange |-> fineZero)
    else $error("rate changed with open fine group");
  chk_same_rate_free: assert property (
    startChange && !rateChange && !needTcrOff |=> state_q == fgr_pkg::ST_SETMODE)
    else $error("same rate swap was delayed");
  chk_fixed1x_free: assert property (
    startChange && activeRate == fgr_pkg::FLV_1X && !needTcrOff |=> modeSet)
    else $error("change from fixed 1x was delayed");
  chk_tcr_only_1x: assert property (
    mrsStrobe_q && mrsTcr_q |-> mrsMode_q == fgr_pkg::MODE_FIX1X)
    else $error("temperature refresh with fine mode");
  chk_tcr_off_order: assert property (
    tcrOffGo |=> s_tcr_then_mode)
    else $error("mode written before temperature refresh off");
  chk_mode_instant: assert property (
    modeSet |=> activeMode_q == $past(pendMode) && intCount == intervalLen)
    else $error("new interval not applied at change");
  chk_sre_taken: assert property (
    startSre |=> sreStrobe_q && state_q == fgr_pkg::ST_INSR)
    else $error("self refresh entry not issued");
  chk_extra_issued: assert property (
    s_owed_exit |-> ##[1:20] refStrobe_q)
    else $error("owed extra refresh not issued");
  chk_postponed_kept: assert property (
    srxGo |=> owed_q == $past(owed_q))
    else $error("postponed debt disturbed by exit");
  chk_group_clear: assert property (
    srxGo || modeSet |=> fineZero)
    else $error("fine group count not cleared");
endmodule : fgr_refresh_ctrl
`default_nettype wire

// ===== test/ddr4_fgr_model.sv
// behavioural refresh-mode device that counts broken command rules
`timescale 1ns/1ns
`default_nettype none
module ddr4_fgr_model (
  input wire logic mclk, // clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic refStrobe, // refresh command
  input wire logic [1:0] refFlavour, // refresh flavour
  input wire logic mrsStrobe, // refresh mode write
  input wire logic [2:0] mrsMode, // refresh mode field
  input wire logic mrsTcr, // temperature_controlled_refresh enable
  input wire logic sreStrobe, // self refresh entry
  input wire logic srxStrobe, // self refresh exit
  output logic [7:0] violationCnt, // broken command rules seen
  output logic [15:0] refCnt, // refresh commands received
  output logic [2:0] owedLeft // extra refreshes still owed after exit
);
  logic [2:0] modeQ;
  logic tcrQ;
  logic inSrQ;
  logic owedQ;
  logic [1:0] groupQ;
  int sinceQ;
  int gapQ;

  always @(posedge mclk) begin : watch
    int v;
    v = 0;
    if (!resetn) begin
      modeQ <= fgr_pkg::MODE_FIX1X;
      tcrQ <= 1'b0;
      inSrQ <= 1'b0;
      owedQ <= 1'b0;
      groupQ <= 2'h0;
      sinceQ <= 1000;
      gapQ <= 0;
      violationCnt <= 8'h00;
      refCnt <= 16'h0000;
      owedLeft <= 3'h0;
    end else begin
      sinceQ <= sinceQ + 1;
      if ((refStrobe || mrsStrobe || sreStrobe) && sinceQ < gapQ) v++;
      if (refStrobe) begin
        refCnt <= refCnt + 16'h0001;
        sinceQ <= 1;
        gapQ <= (refFlavour == fgr_pkg::FLV_1X) ? int'(fgr_pkg::TRFC1_CYC) :
          (refFlavour == fgr_pkg::FLV_2X) ? int'(fgr_pkg::TRFC2_CYC) :
          int'(fgr_pkg::TRFC4_CYC);
        if (inSrQ || !(refFlavour == modeQ[1:0] ||
            (refFlavour == fgr_pkg::FLV_1X && modeQ[2]))) v++;
        if (refFlavour == fgr_pkg::FLV_1X) begin
          if (modeQ[2] && groupQ != 2'h0) v++;
          groupQ <= 2'h0;
          owedLeft <= 3'h0;
        end else begin
          groupQ <= modeQ[1] ? groupQ + 2'h1 : {1'b0, ~groupQ[0]};
          owedLeft <= (owedLeft != 3'h0) ? owedLeft - 3'h1 : 3'h0;
        end
      end
      if (mrsStrobe) begin
        if (inSrQ || (mrsMode[1:0] != modeQ[1:0] && groupQ != 2'h0)) v++;
        if (mrsMode != fgr_pkg::MODE_FIX1X && (mrsTcr || tcrQ)) v++;
        modeQ <= mrsMode;
        tcrQ <= mrsTcr;
        groupQ <= 2'h0;
      end
      if (sreStrobe) begin
        if (inSrQ || owedLeft != 3'h0) v++;
        inSrQ <= 1'b1;
        owedQ <= (groupQ != 2'h0);
      end
      if (srxStrobe) begin
        if (!inSrQ) v++;
        inSrQ <= 1'b0;
        groupQ <= 2'h0;
        sinceQ <= 1;
        gapQ <= int'(fgr_pkg::TXS_CYC);
        owedLeft <= !owedQ ? 3'h0 : modeQ[1] ? fgr_pkg::EXTRA_4X : fgr_pkg::EXTRA_2X;
      end
      violationCnt <= violationCnt + 8'(v);
    end
  end
endmodule : ddr4_fgr_model
`default_nettype wire

// ===== test/fgr_refresh_ctrl_test.sv
// self-checking bench for the fine granularity refresh controller
`timescale 1ns/1ns
`default_nettype none
module fgr_refresh_ctrl_test;
  localparam logic [2:0] MODES [0:4] = '{fgr_pkg::MODE_FIX1X, fgr_pkg::MODE_FIX2X,
    fgr_pkg::MODE_FIX4X, fgr_pkg::MODE_OTF12, fgr_pkg::MODE_OTF14};
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata;
  logic refStrobe;
  logic [1:0] refFlavour;
  logic mrsStrobe;
  logic [2:0] mrsMode;
  logic mrsTcr;
  logic sreStrobe;
  logic srxStrobe;
  logic [7:0] violationCnt;
  logic [15:0] refCnt;
  logic [2:0] owedLeft;
  int errorCnt = 0;
  int totalChecks = 0;
  int cycles = 0;
  int refSeen = 0;

  fgr_refresh_ctrl fgr_refresh_ctrl_i (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .refStrobe(refStrobe), .refFlavour(refFlavour), .mrsStrobe(mrsStrobe),
    .mrsMode(mrsMode), .mrsTcr(mrsTcr), .sreStrobe(sreStrobe), .srxStrobe(srxStrobe));
  ddr4_fgr_model ddr4_fgr_model_i (.mclk(mclk), .resetn(resetn), .refStrobe(refStrobe),
    .refFlavour(refFlavour), .mrsStrobe(mrsStrobe), .mrsMode(mrsMode), .mrsTcr(mrsTcr),
    .sreStrobe(sreStrobe), .srxStrobe(srxStrobe), .violationCnt(violationCnt),
    .refCnt(refCnt), .owedLeft(owedLeft));

  always #25 mclk = ~mclk;

  task automatic results;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  always @(posedge mclk) begin
    cycles++;
    if (refStrobe === 1'b1) refSeen++;
    if (cycles == 60000) begin
      errorCnt++;
      results();
    end
  end

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g, input int tol);
    totalChecks++;
    if (g !== e && (tol == 0 || g > e + tol || g + tol < e)) begin
      errorCnt++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask : cmp

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    d = regRdata;
  endtask : rd

  // expected interval: base shortened by rate and temperature band
  function automatic logic [31:0] gap(input int r, input int b);
    return 32'(fgr_pkg::TREFI_BASE_CYC) >> (r + ((b > 2) ? 2 : b));
  endfunction : gap

  task automatic apply(input logic [7:0] cfg);
    logic [31:0] s;
    wr(fgr_pkg::ADDR_CFG, {24'h0, cfg});
    wr(fgr_pkg::ADDR_CMD, 32'h1 << fgr_pkg::CMD_APPLY_BIT);
    for (int i = 0; i < 200; i++) begin
      rd(fgr_pkg::ADDR_STATUS, s);
      if (s[22:20] === 3'h0 && s[6] === 1'b0) break;
    end
    cmp("active mode", {29'h0, cfg[2:0]}, {29'h0, s[2:0]}, 0);
    cmp("active tcr", {31'h0, cfg[3] && cfg[2:0] == 3'h0}, {31'h0, s[3]}, 0);
    rd(fgr_pkg::ADDR_CFG, s);
    cmp("config readback", {24'h0, cfg}, s, 0);
  endtask : apply

  task automatic waitRef(output int t);
    int k;
    k = 0;
    @(posedge mclk);
    while (refStrobe !== 1'b1 && k < 2000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 2000) cmp("refresh seen", 1, 0, 0);
    t = int'($time / 50);
  endtask : waitRef

  initial begin
    logic [31:0] s;
    logic [31:0] s2;
    int t0;
    int t1;
    int n;
    void'($urandom(32'hCE11));
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    rd(fgr_pkg::ADDR_CFG, s);
    cmp("config reset", {24'h0, fgr_pkg::CFG_RESET}, s, 0);
    rd(fgr_pkg::ADDR_CMD, s);
    cmp("command read", 0, s, 0);
    rd(4'h2, s);
    cmp("unmapped read", 0, s, 0);
    rd(fgr_pkg::ADDR_STATUS, s);
    cmp("status reset", 0, {24'h0, s[7:0]}, 0);
    apply(8'h08);
    apply({5'h00, fgr_pkg::MODE_FIX2X});
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 4; b++) begin
        apply({2'b00, 2'(b), 1'b0, MODES[r]});
        for (int i = 0; i < 4; i++) waitRef(t0);
        waitRef(t1);
        cmp("refresh interval", gap(r, b), 32'(t1 - t0), 0);
      end
    end
    // odd or partial fine group at self refresh entry, regular refresh held
    for (int r = 1; r < 3; r++) begin
      apply({5'h00, MODES[r]});
      for (int i = 0; i < 8; i++) begin
        waitRef(t0);
        rd(fgr_pkg::ADDR_STATUS, s);
        if (s[9:8] !== 2'h0) break;
      end
      wr(fgr_pkg::ADDR_CFG, {24'h0, 5'h10, MODES[r]});
      rd(fgr_pkg::ADDR_STATUS, s);
      n = refSeen;
      wr(fgr_pkg::ADDR_CMD, 32'h1 << fgr_pkg::CMD_SRE_BIT);
      repeat (20) @(posedge mclk);
      rd(fgr_pkg::ADDR_STATUS, s2);
      cmp("in self refresh", 1, {31'h0, s2[5]}, 0);
      cmp("extra owed", {31'h0, s[9:8] != 2'h0}, {31'h0, s2[7]}, 0);
      wr(fgr_pkg::ADDR_CMD, 32'h1 << fgr_pkg::CMD_SRX_BIT);
      repeat (60) @(posedge mclk);
      rd(fgr_pkg::ADDR_REFCNT, s2);
      cmp("extras issued", (s[9:8] != 2'h0) ? ((r == 1) ? 2 : 4) : 0, 32'(refSeen - n), 0);
      cmp("extras left", 0, {29'h0, owedLeft}, 0);
      cmp("refresh count", {16'h0, refCnt}, {16'h0, s2[15:0]}, 0);
    end
    for (int i = 0; i < 10; i++) begin
      apply({1'(($urandom % 4) == 0), 1'($urandom), 2'($urandom), 1'($urandom),
        MODES[$urandom % 5]});
      repeat ($urandom % 300) @(posedge mclk);
      if ($urandom % 2) begin
        wr(fgr_pkg::ADDR_CMD, 32'h1 << fgr_pkg::CMD_SRE_BIT);
        repeat (30 + $urandom % 50) @(posedge mclk);
        wr(fgr_pkg::ADDR_CMD, 32'h1 << fgr_pkg::CMD_SRX_BIT);
        repeat (60) @(posedge mclk);
        cmp("extras left", 0, {29'h0, owedLeft}, 0);
      end
    end
    @(negedge mclk);
    cmp("device rule breaks", 0, {24'h0, violationCnt}, 0);
    results();
  end
endmodule : fgr_refresh_ctrl_test
`default_nettype wire
